// *** verilog/cpfc_cfg.svh ***
// Constants of the charger protection and fault control block
`ifndef CPFC_CFG_SVH
`define CPFC_CFG_SVH
// Register byte offsets
`define CPFC_OFS_OPTION 8'h00
`define CPFC_OFS_CHGCUR 8'h04
`define CPFC_OFS_STATUS 8'h08
// Reset values
`define CPFC_OPTION_RST 32'h0000_0000
`define CPFC_CHGCUR_RST 16'h0000
// Option register fields
`define CPFC_OPT_HS_LO 7
`define CPFC_OPT_HS_HI 8
`define CPFC_OPT_FREQ_EN 9
`define CPFC_OPT_FREQ_UP 10
// Timing
`define CPFC_CLK_MHZ 250
`define CPFC_OVP_MS 30
`define CPFC_LOW_MS 1
`define CPFC_BLANK_NS 100
`define CPFC_OVP_CYC (`CPFC_OVP_MS * 1000 * `CPFC_CLK_MHZ)
`define CPFC_LOW_CYC (`CPFC_LOW_MS * 1000 * `CPFC_CLK_MHZ)
`define CPFC_BLANK_CYC ((`CPFC_BLANK_NS * `CPFC_CLK_MHZ + 999) / 1000)
// Peak charge overcurrent levels, milliamps on a 10 mOhm sense resistor
`define CPFC_OCP_SEL1_MA 16'h0BB8
`define CPFC_OCP_SEL2_MA 16'h1770
`define CPFC_OCP_LVL0_MA 16'h1770
`define CPFC_OCP_LVL1_MA 16'h2328
`define CPFC_OCP_LVL2_MA 16'h2EE0
// Short-detection thresholds, millivolts, and the short count limit
`define CPFC_HS_MV0 10'h12C
`define CPFC_HS_MV1 10'h1F4
`define CPFC_HS_MV2 10'h2BC
`define CPFC_HS_MV3 10'h384
`define CPFC_LS_MV 10'h06E
`define CPFC_SHORT_LIMIT 3'h7
// AXI responses
`define CPFC_RESP_OKAY 2'h0
`define CPFC_RESP_SLVERR 2'h2
`endif

// *** verilog/cpfc_pkg.sv ***
// Types of the charger protection and fault control block
package cpfc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RUN,
      ST_LOWHOLD,
      ST_THERMAL,
      ST_OVPDIS,
      ST_LATCH
   } cpfc_state_e;

   // Analog comparator and supply inputs, asynchronous to clk
   typedef struct packed {
      logic peakChargeOvercurrent;
      logic batteryOvervoltage;
      logic batteryLowVoltage;
      logic hotAbove155;
      logic coolBelow135;
      logic highSideShort;
      logic lowSideShort;
      logic supplyUndervoltageLockout;
      logic adapterDetectLow;
   } cpfc_cmp_s;

   // Requests from the PWM, same clock
   typedef struct packed {
      logic cycleStart;
      logic highReq;
      logic lowReq;
      logic refreshReq;
   } cpfc_pwm_s;

   // Power switch controls
   typedef struct packed {
      logic highSideSwitch;
      logic lowSideSwitch;
      logic adapterInputSwitch;
      logic reverseBlockSwitch;
      logic batteryPathSwitch;
   } cpfc_sw_s;
endpackage

// *** verilog/cpfc_top.sv ***
// Charger protection and fault control with AXI4-Lite registers
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cpfc_cfg.svh"
module cpfc_top #(
   parameter int unsigned OVP_CYC = `CPFC_OVP_CYC,
   parameter int unsigned LOW_CYC = `CPFC_LOW_CYC
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                ce,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output var  logic                s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output var  logic                s_axi_wready,
   output var  logic [1:0]          s_axi_bresp,
   output var  logic                s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output var  logic                s_axi_arready,
   output var  logic [31:0]         s_axi_rdata,
   output var  logic [1:0]          s_axi_rresp,
   output var  logic                s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire cpfc_pkg::cpfc_cmp_s cmpIn,
   input  wire cpfc_pkg::cpfc_pwm_s pwm,
   input  wire logic                chargeEnableOk,
   output var  cpfc_pkg::cpfc_sw_s  swCtl,
   output var  logic                chargerEnabled,
   output var  logic                softStartReq,
   output var  logic                batteryDischargeSink,
   output var  logic                chargeCurrentLimitLow,
   output var  logic                regulatorLimitLow,
   output var  logic                freqAdjustEn,
   output var  logic                freqAdjustRaise,
   output var  logic [15:0]         ocpThresholdMa,
   output var  logic [9:0]          highSideShortMv,
   output var  logic [9:0]          lowSideShortMv,
   output var  logic                latchedOff
);
   import cpfc_pkg::*;

   localparam logic [7:0] BLANK_CYC = 8'(`CPFC_BLANK_CYC);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   cpfc_cmp_s cmpS1_q, cmpS2_q;
   cpfc_cmp_s cmpS1_d, cmpS2_d;

   always_comb begin
      cmpS1_d = cmpIn;
      cmpS2_d = cmpS1_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmpS1_q <= '0;
         cmpS2_q <= '0;
      end else if (ce) begin
         cmpS1_q <= cmpS1_d;
         cmpS2_q <= cmpS2_d;
      end
   end

   logic ovpS, lowS, releaseS;
   assign ovpS     = cmpS2_q.batteryOvervoltage;
   assign lowS     = cmpS2_q.batteryLowVoltage;
   assign releaseS = cmpS2_q.supplyUndervoltageLockout | cmpS2_q.adapterDetectLow;

   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   logic [31:0] option_q, option_d;
   logic [15:0] chgCur_q, chgCur_d;
   logic        awHave_q, awHave_d, wHave_q, wHave_d;
   logic [7:0]  awAddr_q, awAddr_d;
   logic [31:0] wData_q, wData_d;
   logic [3:0]  wStrb_q, wStrb_d;
   logic        bValid_q, bValid_d, rValid_q, rValid_d;
   logic [1:0]  bResp_q, bResp_d, rResp_q, rResp_d;
   logic [31:0] rData_q, rData_d;
   logic [31:0] statusWord;

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // Ready outputs drop while frozen so no beat is lost; bvalid and rvalid hold
   assign s_axi_awready = ce & ~awHave_q & ~bValid_q;
   assign s_axi_wready  = ce & ~wHave_q & ~bValid_q;
   assign s_axi_arready = ce & ~rValid_q;
   assign s_axi_bvalid  = bValid_q;
   assign s_axi_bresp   = bResp_q;
   assign s_axi_rvalid  = rValid_q;
   assign s_axi_rresp   = rResp_q;
   assign s_axi_rdata   = rData_q;

   always_comb begin
      logic [31:0] merged;
      merged   = mergeBytes(option_q, wData_q, wStrb_q);
      option_d = option_q;
      chgCur_d = chgCur_q;
      awHave_d = awHave_q;
      awAddr_d = awAddr_q;
      wHave_d  = wHave_q;
      wData_d  = wData_q;
      wStrb_d  = wStrb_q;
      bValid_d = bValid_q;
      bResp_d  = bResp_q;
      rValid_d = rValid_q;
      rResp_d  = rResp_q;
      rData_d  = rData_q;
      if (s_axi_awvalid && s_axi_awready) begin
         awHave_d = 1'b1;
         awAddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wHave_d = 1'b1;
         wData_d = s_axi_wdata;
         wStrb_d = s_axi_wstrb;
      end
      // Write commits one cycle after both halves are held
      if (awHave_q && wHave_q && !bValid_q) begin
         awHave_d = 1'b0;
         wHave_d  = 1'b0;
         bValid_d = 1'b1;
         bResp_d  = `CPFC_RESP_OKAY;
         case (awAddr_q[7:2])
            6'(`CPFC_OFS_OPTION >> 2): option_d = merged;
            6'(`CPFC_OFS_CHGCUR >> 2): begin
               merged   = mergeBytes({16'h0000, chgCur_q}, wData_q, wStrb_q);
               chgCur_d = merged[15:0];
            end
            6'(`CPFC_OFS_STATUS >> 2): bResp_d = `CPFC_RESP_OKAY;
            default: bResp_d = `CPFC_RESP_SLVERR;
         endcase
      end
      if (bValid_q && s_axi_bready) begin
         bValid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rValid_d = 1'b1;
         rResp_d  = `CPFC_RESP_OKAY;
         case (s_axi_araddr[7:2])
            6'(`CPFC_OFS_OPTION >> 2): rData_d = option_q;
            6'(`CPFC_OFS_CHGCUR >> 2): rData_d = {16'h0000, chgCur_q};
            6'(`CPFC_OFS_STATUS >> 2): rData_d = statusWord;
            default: begin
               rData_d = 32'h0000_0000;
               rResp_d = `CPFC_RESP_SLVERR;
            end
         endcase
      end else if (rValid_q && s_axi_rready) begin
         rValid_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         option_q <= `CPFC_OPTION_RST;
         chgCur_q <= `CPFC_CHGCUR_RST;
         awHave_q <= 1'b0;
         awAddr_q <= 8'h00;
         wHave_q  <= 1'b0;
         wData_q  <= 32'h0000_0000;
         wStrb_q  <= 4'h0;
         bValid_q <= 1'b0;
         bResp_q  <= 2'h0;
         rValid_q <= 1'b0;
         rResp_q  <= 2'h0;
         rData_q  <= 32'h0000_0000;
      end else if (ce) begin
         option_q <= option_d;
         chgCur_q <= chgCur_d;
         awHave_q <= awHave_d;
         awAddr_q <= awAddr_d;
         wHave_q  <= wHave_d;
         wData_q  <= wData_d;
         wStrb_q  <= wStrb_d;
         bValid_q <= bValid_d;
         bResp_q  <= bResp_d;
         rValid_q <= rValid_d;
         rResp_q  <= rResp_d;
         rData_q  <= rData_d;
      end
   end

   // ------------------------------------------------------------
   // Supervisor state, timers and short counters
   // ------------------------------------------------------------
   cpfc_state_e st_q, st_d;
   logic [31:0] ovpCnt_q, ovpCnt_d, lowCnt_q, lowCnt_d;
   logic [7:0]  onCnt_q [2], onCnt_d [2];
   logic [1:0]  evDone_q, evDone_d;
   logic [2:0]  shortCnt_q [2], shortCnt_d [2];
   logic        gateOn [2];
   logic        shortCmp [2];
   logic        shortHit;
   logic        lim_q, lim_d;

   assign gateOn[0]   = swCtl.highSideSwitch;
   assign gateOn[1]   = swCtl.lowSideSwitch;
   assign shortCmp[0] = cmpS2_q.highSideShort;
   assign shortCmp[1] = cmpS2_q.lowSideShort;
   assign shortHit    = (shortCnt_q[0] == `CPFC_SHORT_LIMIT) |
                        (shortCnt_q[1] == `CPFC_SHORT_LIMIT);

   always_comb begin
      st_d     = st_q;
      ovpCnt_d = 32'h0;
      lowCnt_d = 32'h0;
      evDone_d = evDone_q;
      // A switch is only judged after its blanking time, once per on-time
      for (int i = 0; i < 2; i++) begin
         onCnt_d[i]    = 8'h00;
         shortCnt_d[i] = shortCnt_q[i];
         if (gateOn[i]) begin
            onCnt_d[i] = (onCnt_q[i] == BLANK_CYC) ? onCnt_q[i] : onCnt_q[i] + 8'h01;
         end else begin
            evDone_d[i] = 1'b0;
         end
         // A pulse cut early never reaches the blanking count
         if (gateOn[i] && onCnt_q[i] == BLANK_CYC && shortCmp[i] && !evDone_q[i] &&
             shortCnt_q[i] != `CPFC_SHORT_LIMIT) begin
            shortCnt_d[i] = shortCnt_q[i] + 3'h1;
            evDone_d[i]   = 1'b1;
         end
      end
      if (releaseS) begin
         st_d = ST_IDLE;
         for (int i = 0; i < 2; i++) begin
            shortCnt_d[i] = 3'h0;
         end
         evDone_d = 2'b00;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (shortHit) begin
                  st_d = ST_LATCH;
               end else if (cmpS2_q.hotAbove155) begin
                  st_d = ST_THERMAL;
               end else if (chargeEnableOk && !ovpS) begin
                  st_d = lowS ? ST_LOWHOLD : ST_RUN;
               end
            end
            ST_RUN: begin
               if (ovpS) begin
                  ovpCnt_d = ovpCnt_q + 32'h1;
               end
               if (shortHit) begin
                  st_d = ST_LATCH;
               end else if (cmpS2_q.hotAbove155) begin
                  st_d = ST_THERMAL;
               end else if (ovpS && ovpCnt_q == OVP_CYC - 1) begin
                  st_d = ST_OVPDIS;
               end else if (!chargeEnableOk) begin
                  st_d = ST_IDLE;
               end else if (lowS && !lim_q) begin
                  // Only a fresh drop starts a hold-off; a lasting low runs limited
                  st_d = ST_LOWHOLD;
               end
            end
            ST_LOWHOLD: begin
               lowCnt_d = lowCnt_q + 32'h1;
               if (shortHit) begin
                  st_d = ST_LATCH;
               end else if (cmpS2_q.hotAbove155) begin
                  st_d = ST_THERMAL;
               end else if (lowCnt_q == LOW_CYC - 1) begin
                  st_d = chargeEnableOk ? ST_RUN : ST_IDLE;
               end
            end
            ST_THERMAL: begin
               if (shortHit) begin
                  st_d = ST_LATCH;
               end else if (cmpS2_q.coolBelow135) begin
                  st_d = ST_IDLE;
               end
            end
            ST_OVPDIS: begin
               if (shortHit) begin
                  st_d = ST_LATCH;
               end else if (!ovpS) begin
                  st_d = ST_IDLE;
               end
            end
            ST_LATCH: st_d = ST_LATCH;
            default: st_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q     <= ST_IDLE;
         ovpCnt_q <= 32'h0;
         lowCnt_q <= 32'h0;
         evDone_q <= 2'b00;
         for (int i = 0; i < 2; i++) begin
            onCnt_q[i]    <= 8'h00;
            shortCnt_q[i] <= 3'h0;
         end
      end else if (ce) begin
         st_q     <= st_d;
         ovpCnt_q <= ovpCnt_d;
         lowCnt_q <= lowCnt_d;
         evDone_q <= evDone_d;
         for (int i = 0; i < 2; i++) begin
            onCnt_q[i]    <= onCnt_d[i];
            shortCnt_q[i] <= shortCnt_d[i];
         end
      end
   end

   // ------------------------------------------------------------
   // Gate drive and analog selects
   // ------------------------------------------------------------
   logic       ocpCut_q, ocpCut_d;
   cpfc_sw_s   sw_q, sw_d;
   logic       en_q, en_d, ss_q, ss_d, sink_q, sink_d;
   logic       reg_q, reg_d, fEn_q, fEn_d, fUp_q, fUp_d;
   logic [15:0] ocp_q, ocp_d;
   logic [9:0]  hsMv_q, hsMv_d;
   logic       running;

   assign running = (st_q == ST_RUN);

   always_comb begin
      // Cut holds for the rest of the cycle; next cycle start clears it
      ocpCut_d = pwm.cycleStart ? 1'b0 :
                 (ocpCut_q | (cmpS2_q.peakChargeOvercurrent & sw_q.highSideSwitch));
      sw_d.highSideSwitch = pwm.highReq & running & ~ovpS & ~ocpCut_d;
      sw_d.lowSideSwitch  = pwm.lowReq & running & ~ovpS &
                            (~lowS | pwm.refreshReq);
      sw_d.adapterInputSwitch = (st_d != ST_LATCH);
      sw_d.reverseBlockSwitch = (st_d != ST_LATCH);
      sw_d.batteryPathSwitch  = (st_d == ST_LATCH) | cmpS2_q.adapterDetectLow;
      en_d   = (st_d == ST_RUN);
      ss_d   = (st_d == ST_RUN) && (st_q != ST_RUN);
      sink_d = ovpS;
      lim_d  = lowS;
      reg_d  = (st_d == ST_THERMAL);
      fEn_d  = option_q[`CPFC_OPT_FREQ_EN];
      fUp_d  = option_q[`CPFC_OPT_FREQ_EN] & option_q[`CPFC_OPT_FREQ_UP];
      if (chgCur_q < `CPFC_OCP_SEL1_MA) begin
         ocp_d = `CPFC_OCP_LVL0_MA;
      end else if (chgCur_q < `CPFC_OCP_SEL2_MA) begin
         ocp_d = `CPFC_OCP_LVL1_MA;
      end else begin
         ocp_d = `CPFC_OCP_LVL2_MA;
      end
      case (option_q[`CPFC_OPT_HS_HI:`CPFC_OPT_HS_LO])
         2'h0: hsMv_d = `CPFC_HS_MV0;
         2'h1: hsMv_d = `CPFC_HS_MV1;
         2'h2: hsMv_d = `CPFC_HS_MV2;
         default: hsMv_d = `CPFC_HS_MV3;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ocpCut_q <= 1'b0;
         sw_q     <= 5'b00110;
         en_q     <= 1'b0;
         ss_q     <= 1'b0;
         sink_q   <= 1'b0;
         lim_q    <= 1'b0;
         reg_q    <= 1'b0;
         fEn_q    <= 1'b0;
         fUp_q    <= 1'b0;
         ocp_q    <= `CPFC_OCP_LVL0_MA;
         hsMv_q   <= `CPFC_HS_MV0;
      end else if (ce) begin
         ocpCut_q <= ocpCut_d;
         sw_q     <= sw_d;
         en_q     <= en_d;
         ss_q     <= ss_d;
         sink_q   <= sink_d;
         lim_q    <= lim_d;
         reg_q    <= reg_d;
         fEn_q    <= fEn_d;
         fUp_q    <= fUp_d;
         ocp_q    <= ocp_d;
         hsMv_q   <= hsMv_d;
      end
   end

   assign swCtl                 = sw_q;
   assign chargerEnabled        = en_q;
   assign softStartReq          = ss_q;
   assign batteryDischargeSink  = sink_q;
   assign chargeCurrentLimitLow = lim_q;
   assign regulatorLimitLow     = reg_q;
   assign freqAdjustEn          = fEn_q;
   assign freqAdjustRaise       = fUp_q;
   assign ocpThresholdMa        = ocp_q;
   assign highSideShortMv       = hsMv_q;
   assign lowSideShortMv        = `CPFC_LS_MV;
   assign latchedOff            = (st_q == ST_LATCH);
   assign statusWord = {17'h00000, shortCnt_q[1], 1'b0, shortCnt_q[0],
                        ocpCut_q, latchedOff, reg_q, lowS, ovpS, st_q};

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence sHoldDone;
      ce && !releaseS && st_q == ST_LOWHOLD && lowCnt_q == LOW_CYC - 1 &&
      chargeEnableOk && !shortHit && !cmpS2_q.hotAbove155;
   endsequence
   sequence sSoftRestart;
      st_q == ST_RUN && softStartReq && chargerEnabled;
   endsequence

   a_ocp_cut_gate: assert property (ocpCut_q |-> !swCtl.highSideSwitch)
      else $error("high gate on during overcurrent cut");
   a_ovp_gates_off: assert property (ce && ovpS |=>
      !swCtl.highSideSwitch && !swCtl.lowSideSwitch)
      else $error("switch on during overvoltage");
   a_ovp_timeout: assert property (ce && !releaseS && st_q == ST_RUN && ovpS &&
      !shortHit && !cmpS2_q.hotAbove155 && ovpCnt_q == OVP_CYC - 1 |=>
      st_q == ST_OVPDIS && !chargerEnabled)
      else $error("overvoltage timeout missed");
   a_sink_follow: assert property (ce |=> batteryDischargeSink == $past(ovpS))
      else $error("sink not tracking overvoltage");
   a_low_hold: assert property (st_q == ST_LOWHOLD |-> !chargerEnabled)
      else $error("charging during hold-off");
   a_low_restart: assert property (sHoldDone |=> sSoftRestart)
      else $error("no soft restart after hold-off");
   a_low_limit: assert property (ce && lowS && !pwm.refreshReq |=>
      chargeCurrentLimitLow && !swCtl.lowSideSwitch)
      else $error("battery-low limit missing");
   a_thermal_off: assert property (st_q == ST_THERMAL |->
      regulatorLimitLow && !chargerEnabled)
      else $error("thermal shutdown not enforced");
   a_freq_dir: assert property (freqAdjustRaise |-> freqAdjustEn)
      else $error("frequency raised while adjust off");
   a_short_latch: assert property (ce && !releaseS && shortHit |=>
      latchedOff && !swCtl.adapterInputSwitch && swCtl.batteryPathSwitch)
      else $error("latch-off not entered");
   a_latch_release: assert property (ce && latchedOff && releaseS |=>
      !latchedOff && shortCnt_q[0] == 3'h0 && shortCnt_q[1] == 3'h0)
      else $error("latch release failed");
   a_latch_hold: assert property (latchedOff && !releaseS |=> latchedOff)
      else $error("latch left without release");
endmodule // cpfc_top
`default_nettype wire

// *** dv/cpfc_power_stage.sv ***
// Far-side model: power switches, inductor and sense comparators
`timescale 1ns/1ps
`default_nettype none
module cpfc_power_stage (
   input  wire logic           clk,
   input  wire cpfc_pkg::cpfc_sw_s swCtl,
   input  wire logic           shortHs,
   input  wire logic [7:0]     ocAfter,
   output var  logic           peakOc,
   output var  logic           hsShort
);
   import cpfc_pkg::*;
   logic [7:0] onCnt;
   always_ff @(posedge clk) begin
      onCnt <= swCtl.highSideSwitch ? onCnt + 8'h01 : 8'h00;
   end
   // Current ramps only while the high side conducts, so a cut drops the trip
   assign peakOc = (ocAfter != 8'h00) && (onCnt >= ocAfter);
   assign hsShort = shortHs & swCtl.highSideSwitch;
endmodule // cpfc_power_stage
`default_nettype wire

// *** dv/test_charger_protection_fault_control.sv ***
// Self-checking bench of the charger protection and fault control block
`timescale 1ns/1ps
`default_nettype none
module test_charger_protection_fault_control;
   import cpfc_pkg::*;
   logic        clk, rst, ce, chargeEnableOk, shortHs, peakOc, hsShort;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, ocAfter;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [15:0] cur, ocpThresholdMa;
   logic [9:0]  highSideShortMv, lowSideShortMv;
   logic        chargerEnabled, softStartReq, batteryDischargeSink, chargeCurrentLimitLow;
   logic        regulatorLimitLow, freqAdjustEn, freqAdjustRaise, latchedOff;
   cpfc_cmp_s   cmp, cmpIn;
   cpfc_pwm_s   pwm;
   cpfc_sw_s    swCtl;
   int          err_count, num_checks, ssCnt, s, i;
   int          seed = 32'hFE7ABAC2;
   // Short counts keep the overvoltage and hold-off timers inside the run
   cpfc_top #(.OVP_CYC(40), .LOW_CYC(20)) dut (.clk, .rst, .ce, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .cmpIn, .pwm, .chargeEnableOk, .swCtl, .chargerEnabled, .softStartReq,
      .batteryDischargeSink, .chargeCurrentLimitLow, .regulatorLimitLow, .freqAdjustEn,
      .freqAdjustRaise, .ocpThresholdMa, .highSideShortMv, .lowSideShortMv, .latchedOff);
   cpfc_power_stage stage (.clk, .swCtl, .shortHs, .ocAfter, .peakOc, .hsShort);
   always_comb begin
      cmpIn = cmp;
      cmpIn.peakChargeOvercurrent = peakOc;
      cmpIn.highSideShort = hsShort;
   end
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (softStartReq === 1'b1) ssCnt <= ssCnt + 1;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (err_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic hang();
      err_count++;
      $display("ERROR %0t: wait timed out", $time);
      summarize();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 50) hang();
   endtask
   task automatic rdr(input logic [7:0] a);
      int n;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 50) hang();
   endtask
   task automatic waitEn();
      int n;
      for (n = 0; n < 200 && chargerEnabled !== 1'b1; n++) @(posedge clk);
      if (n == 200) hang();
      @(posedge clk);
   endtask
   task automatic cyc(input int n);
      @(posedge clk);
      pwm <= cpfc_pwm_s'(4'b1100);
      @(posedge clk);
      pwm <= cpfc_pwm_s'(4'b0100);
      repeat (n) @(posedge clk);
      pwm <= cpfc_pwm_s'(4'b0010);
      repeat (4) @(posedge clk);
   endtask
   function automatic logic [15:0] ocpExp(input logic [15:0] c);
      return c < 16'h0BB8 ? 16'h1770 : (c < 16'h1770 ? 16'h2328 : 16'h2EE0);
   endfunction
   initial begin
      {rst, ce, chargeEnableOk, s_axi_wstrb} = 7'h7F;
      {shortHs, ocAfter, cmp, pwm} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(32'(ocpThresholdMa), 32'h1770);
      chk(32'(lowSideShortMv), 32'h6E);
      for (i = 0; i < 16; i++) begin
         wr(8'h00, 32'(i) << 7);
         repeat (2) @(posedge clk);
         chk(32'(highSideShortMv), 32'h12C + 32'(i % 4) * 32'hC8);
         chk(32'({freqAdjustEn, freqAdjustRaise}), 32'({i[2], i[2] & i[3]}));
      end
      for (i = 0; i < 10; i++) begin
         cur = i < 4 ? 16'h0BB7 + 16'(i % 2) + 16'(i / 2) * 16'h0BB8 : 16'($random(seed));
         wr(8'h04, {16'h0, cur});
         repeat (2) @(posedge clk);
         chk(32'(ocpThresholdMa), 32'(ocpExp(cur)));
      end
      rdr(8'h40);
      chk({rd[29:0], rs}, 32'h2);
      wr(8'h40, 32'h0);
      chk(32'(rs), 32'h2);
      waitEn();
      cmp.batteryOvervoltage <= 1'b1;
      pwm <= cpfc_pwm_s'(4'b0110);
      repeat (6) @(posedge clk);
      chk(32'({swCtl.highSideSwitch, swCtl.lowSideSwitch, chargerEnabled}), 32'h1);
      chk(32'(batteryDischargeSink), 32'h1);
      repeat (50) @(posedge clk);
      chk(32'(chargerEnabled), 32'h0);
      cmp.batteryOvervoltage <= 1'b0;
      pwm <= '0;
      repeat (6) @(posedge clk);
      chk(32'(batteryDischargeSink), 32'h0);
      waitEn();
      cmp.batteryLowVoltage <= 1'b1;
      repeat (6) @(posedge clk);
      chk(32'({chargerEnabled, chargeCurrentLimitLow}), 32'h1);
      s = ssCnt;
      cmp.batteryLowVoltage <= 1'b0;
      waitEn();
      chk(32'(ssCnt), 32'(s + 1));
      cmp.hotAbove155 <= 1'b1;
      repeat (6) @(posedge clk);
      chk(32'({chargerEnabled, regulatorLimitLow}), 32'h1);
      cmp.hotAbove155 <= 1'b0;
      repeat (10) @(posedge clk);
      chk(32'(chargerEnabled), 32'h0);
      s = ssCnt;
      cmp.coolBelow135 <= 1'b1;
      waitEn();
      chk(32'(ssCnt), 32'(s + 1));
      cmp.coolBelow135 <= 1'b0;
      // High request stays up, so only the cut can hold the gate low
      ocAfter <= 8'h08;
      pwm <= cpfc_pwm_s'(4'hC);
      @(posedge clk);
      pwm <= cpfc_pwm_s'(4'h4);
      repeat (20) @(posedge clk);
      chk(32'(swCtl.highSideSwitch), 32'h0);
      pwm <= cpfc_pwm_s'(4'hC);
      @(posedge clk);
      pwm <= cpfc_pwm_s'(4'h4);
      @(posedge clk);
      chk(32'(swCtl.highSideSwitch), 32'h1);
      ocAfter <= 8'h05;
      shortHs <= 1'b1;
      repeat (8) cyc(30);
      rdr(8'h08);
      chk(32'({latchedOff, rd[10:8]}), 32'h0);
      ocAfter <= 8'h00;
      repeat (6) cyc(30);
      chk(32'(latchedOff), 32'h0);
      cyc(30);
      chk(32'({latchedOff, swCtl[2:0]}), 32'h9);
      shortHs <= 1'b0;
      repeat (20) @(posedge clk);
      chk(32'(latchedOff), 32'h1);
      cmp.adapterDetectLow <= 1'b1;
      repeat (6) @(posedge clk);
      rdr(8'h08);
      chk(32'({latchedOff, rd[14:8]}), 32'h0);
      cmp.adapterDetectLow <= 1'b0;
      waitEn();
      // Frozen clock enable must hold state and drop the bus readies
      ce <= 1'b0;
      cmp.hotAbove155 <= 1'b1;
      repeat (10) @(posedge clk);
      chk(32'({chargerEnabled, s_axi_arready}), 32'h2);
      ce <= 1'b1;
      repeat (6) @(posedge clk);
      chk(32'({chargerEnabled, regulatorLimitLow}), 32'h1);
      summarize();
   end
endmodule // test_charger_protection_fault_control
`default_nettype wire
